// ### hw/ntb_ipc_regs.vh
// Purpose: Offsets, field positions, reset values for the bridge block.
// Assumes: Byte offsets within one endpoint's lower 2KB window.
// Notes: Bit 11 of an access address selects the opposite endpoint.
`ifndef NTB_IPC_REGS_VH
`define NTB_IPC_REGS_VH
// ===========================================================
// Register offsets
`define OFF_OMSG0 11'h400
`define OFF_OMSG3 11'h40c
`define OFF_IMSG0 11'h410
`define OFF_IMSG3 11'h41c
`define OFF_ODB 11'h420
`define OFF_IDB 11'h424
`define OFF_ISTS 11'h428
`define OFF_SCR0 11'h430
`define OFF_SCR1 11'h434
`define OFF_BSTS 11'h438
`define OFF_CTRL 11'h43c
`define OFF_PADDR 11'h440
`define OFF_PDATA 11'h444
`define OFF_PGO 11'h448
`define OFF_PRES 11'h44c
// ===========================================================
// Field positions
`define ISTS_DB_BIT 4
`define BSTS_ECRC_BIT 0
`define CTRL_XBLOCK_BIT 0
`define CTRL_NFE_BIT 1
`define PGO_WRITE_BIT 0
// ===========================================================
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_CTRL 2'h0
`define RST_FLAGS 4'h0
// ===========================================================
// CRC constants
`define CRC_POLY 32'h04c1_1db7
`define CRC_SEED 32'hffff_ffff
`endif

// ### hw/ecrc_regen.v
// Purpose: Checks the received ECRC and builds the forwarded one.
// Assumes: start_in marks the first word; last_in the final word.
// Notes: Both CRCs run word-parallel over the same beats.
`timescale 1ns/100ps
`include "ntb_ipc_regs.vh"
module ecrc_regen (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Packet beats
   input wire start_in,
   input wire valid_in,
   input wire last_in,
   input wire [31:0] orig_in,
   input wire [31:0] mod_in,
   input wire has_ecrc_in,
   input wire [31:0] ecrc_in,
   // Result
   output reg done_out,
   output reg err_out,
   output reg [31:0] ecrc_out
);
   // ========================================================
   // CRC step
   function [31:0] crc_step;
      input [31:0] c;
      input [31:0] d;
      integer i;
      reg [31:0] r;
      begin
         r = c;
         for (i = 31; i >= 0; i = i - 1) begin
            if (r[31] ^ d[i]) begin
               r = {r[30:0], 1'b0} ^ `CRC_POLY;
            end else begin
               r = {r[30:0], 1'b0};
            end
         end
         crc_step = r;
      end
   endfunction

   reg [31:0] orig_crc_reg;
   reg [31:0] mod_crc_reg;
   wire [31:0] orig_next;
   wire [31:0] mod_next;
   wire bad;
   assign orig_next = crc_step(start_in ? `CRC_SEED : orig_crc_reg,
                               orig_in);
   assign mod_next = crc_step(start_in ? `CRC_SEED : mod_crc_reg,
                              mod_in);
   assign bad = (~orig_next) != ecrc_in;

   // ========================================================
   // Accumulate and finish
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         orig_crc_reg <= `CRC_SEED;
         mod_crc_reg <= `CRC_SEED;
         done_out <= 1'b0;
         err_out <= 1'b0;
         ecrc_out <= `RST_WORD;
      end else begin
         done_out <= 1'b0;
         err_out <= 1'b0;
         if (valid_in) begin
            orig_crc_reg <= orig_next;
            mod_crc_reg <= mod_next;
            if (last_in && has_ecrc_in) begin
               done_out <= 1'b1;
               err_out <= bad;
               // A bad input CRC is poisoned, not repaired.
               ecrc_out <= bad ? mod_next : ~mod_next;
            end
         end
      end
   end
endmodule // ecrc_regen

// ### hw/ntb_ipc.v
// Purpose: Messages, doorbells, scratchpads, config windows, errors.
// Assumes: Index 0 is the internal endpoint, index 1 the external.
// Notes: Each side has one access port, config or BAR4 memory.
`timescale 1ns/100ps
`include "ntb_ipc_regs.vh"
module ntb_ipc (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Register access, one lane per side
   input wire [1:0] req_valid_in,
   input wire [1:0] req_cfg_in,
   input wire [1:0] req_write_in,
   input wire [23:0] req_addr_in,
   input wire [63:0] req_wdata_in,
   output reg [1:0] rsp_valid_out,
   output reg [63:0] rsp_data_out,
   // Interrupt requests toward each root
   output reg [1:0] irq_out,
   // Forwarded packets, per receiving side
   input wire [1:0] pkt_start_in,
   input wire [1:0] pkt_valid_in,
   input wire [1:0] pkt_last_in,
   input wire [63:0] pkt_orig_in,
   input wire [63:0] pkt_mod_in,
   input wire [1:0] pkt_has_ecrc_in,
   input wire [63:0] pkt_ecrc_in,
   output reg [1:0] fwd_ecrc_valid_out,
   output reg [63:0] fwd_ecrc_out,
   // Error sources and messages
   input wire phy_err_in,
   input wire [1:0] tl_err_in,
   output reg [1:0] nonfatal_msg_out,
   output reg [1:0] err_msg_out,
   // External-side configuration issue
   output reg punch_valid_out,
   output reg punch_write_out,
   output reg [31:0] punch_addr_out,
   output reg [31:0] punch_data_out,
   input wire punch_done_in,
   input wire [31:0] punch_rdata_in
);
   // ========================================================
   // State
   reg [31:0] omsg_reg [0:7];
   reg [31:0] odb_reg [0:1];
   reg [31:0] idb_reg [0:1];
   reg [31:0] scr_reg [0:1];
   reg [3:0] mflag_reg [0:1];
   reg [1:0] bsts_reg;
   reg [1:0] ctrl_reg [0:1];
   reg [31:0] paddr_reg;
   reg [31:0] pdata_reg;
   reg [31:0] pres_reg;

   // ========================================================
   // Window decode
   function tgt_of;
      input side;
      input [11:0] a;
      begin
         tgt_of = a[11] ? ~side : side;
      end
   endfunction

   function [31:0] rd_word;
      input e;
      input [10:0] off;
      begin
         rd_word = `RST_WORD;
         if (off >= `OFF_OMSG0 && off <= `OFF_OMSG3) begin
            rd_word = omsg_reg[{e, off[3:2]}];
         end else if (off >= `OFF_IMSG0 && off <= `OFF_IMSG3) begin
            rd_word = omsg_reg[{~e, off[3:2]}];
         end else begin
            case (off)
               `OFF_ODB: rd_word = odb_reg[e];
               `OFF_IDB: rd_word = idb_reg[e];
               `OFF_ISTS: begin
                  rd_word[3:0] = mflag_reg[e];
                  rd_word[`ISTS_DB_BIT] = |idb_reg[e];
               end
               `OFF_SCR0: rd_word = scr_reg[0];
               `OFF_SCR1: rd_word = scr_reg[1];
               `OFF_BSTS: rd_word[`BSTS_ECRC_BIT] = bsts_reg[e];
               `OFF_CTRL: rd_word[1:0] = ctrl_reg[e];
               `OFF_PADDR: rd_word = e ? `RST_WORD : paddr_reg;
               `OFF_PDATA: rd_word = e ? `RST_WORD : pdata_reg;
               `OFF_PRES: rd_word = e ? `RST_WORD : pres_reg;
               default: rd_word = `RST_WORD;
            endcase
         end
      end
   endfunction

   wire [1:0] tgt_w;
   wire [1:0] acc_w;
   wire [1:0] wr_w;
   wire [21:0] off_w;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : dec
         wire [11:0] a;
         assign a = req_addr_in[g*12 +: 12];
         assign tgt_w[g] = tgt_of(g[0], a);
         assign off_w[g*11 +: 11] = {a[10:2], 2'b00};
         // Memory (BAR4) accesses to the far window are never blocked.
         assign acc_w[g] = req_valid_in[g] &
            ~(req_cfg_in[g] & a[11] &
              ctrl_reg[tgt_w[g]][`CTRL_XBLOCK_BIT]);
         assign wr_w[g] = acc_w[g] & req_write_in[g];
      end
   endgenerate

   // ========================================================
   // Set and clear masks from both lanes
   reg [63:0] idb_set;
   reg [63:0] idb_clr;
   reg [7:0] mf_set;
   reg [7:0] mf_clr;
   reg [1:0] bs_clr;
   integer p;
   always @* begin
      idb_set = 64'h0;
      idb_clr = 64'h0;
      mf_set = 8'h0;
      mf_clr = 8'h0;
      bs_clr = 2'h0;
      for (p = 0; p < 2; p = p + 1) begin
         if (wr_w[p]) begin
            if (off_w[p*11 +: 11] == `OFF_ODB) begin
               if (tgt_w[p]) begin
                  idb_set[31:0] = idb_set[31:0] |
                     req_wdata_in[p*32 +: 32];
               end else begin
                  idb_set[63:32] = idb_set[63:32] |
                     req_wdata_in[p*32 +: 32];
               end
            end
            if (off_w[p*11 +: 11] == `OFF_IDB) begin
               if (tgt_w[p]) begin
                  idb_clr[63:32] = idb_clr[63:32] |
                     req_wdata_in[p*32 +: 32];
               end else begin
                  idb_clr[31:0] = idb_clr[31:0] |
                     req_wdata_in[p*32 +: 32];
               end
            end
            if (off_w[p*11 +: 11] >= `OFF_OMSG0 &&
                off_w[p*11 +: 11] <= `OFF_OMSG3) begin
               mf_set[{~tgt_w[p], off_w[p*11+2 +: 2]}] = 1'b1;
            end
            if (off_w[p*11 +: 11] == `OFF_ISTS) begin
               mf_clr[tgt_w[p]*4 +: 4] = mf_clr[tgt_w[p]*4 +: 4] |
                  req_wdata_in[p*32 +: 4];
            end
            if (off_w[p*11 +: 11] == `OFF_BSTS) begin
               bs_clr[tgt_w[p]] = bs_clr[tgt_w[p]] |
                  req_wdata_in[p*32 + `BSTS_ECRC_BIT];
            end
         end
      end
   end

   // ========================================================
   // ECRC regeneration, one per receiving side
   wire [1:0] ecrc_done;
   wire [1:0] ecrc_err;
   wire [63:0] ecrc_val;
   generate
      for (g = 0; g < 2; g = g + 1) begin : crc
         ecrc_regen u_regen (
            .sys_clk_in(sys_clk_in),
            .rstn_in(rstn_in),
            .start_in(pkt_start_in[g]),
            .valid_in(pkt_valid_in[g]),
            .last_in(pkt_last_in[g]),
            .orig_in(pkt_orig_in[g*32 +: 32]),
            .mod_in(pkt_mod_in[g*32 +: 32]),
            .has_ecrc_in(pkt_has_ecrc_in[g]),
            .ecrc_in(pkt_ecrc_in[g*32 +: 32]),
            .done_out(ecrc_done[g]),
            .err_out(ecrc_err[g]),
            .ecrc_out(ecrc_val[g*32 +: 32])
         );
      end
   endgenerate

   // ========================================================
   // Flags, doorbells, errors
   integer e;
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (e = 0; e < 2; e = e + 1) begin
            idb_reg[e] <= `RST_WORD;
            mflag_reg[e] <= `RST_FLAGS;
         end
         bsts_reg <= 2'h0;
         irq_out <= 2'h0;
         fwd_ecrc_valid_out <= 2'h0;
         fwd_ecrc_out <= 64'h0;
         nonfatal_msg_out <= 2'h0;
         err_msg_out <= 2'h0;
      end else begin
         for (e = 0; e < 2; e = e + 1) begin
            // A ring in the same cycle as a clear survives.
            idb_reg[e] <= (idb_reg[e] & ~idb_clr[e*32 +: 32]) |
               idb_set[e*32 +: 32];
            mflag_reg[e] <= (mflag_reg[e] & ~mf_clr[e*4 +: 4]) |
               mf_set[e*4 +: 4];
            irq_out[e] <= (|mflag_reg[e]) | (|idb_reg[e]);
            nonfatal_msg_out[e] <= ecrc_err[e] &
               ctrl_reg[e][`CTRL_NFE_BIT];
         end
         bsts_reg <= (bsts_reg & ~bs_clr) | ecrc_err;
         fwd_ecrc_valid_out <= ecrc_done;
         fwd_ecrc_out <= ecrc_val;
         // Link faults belong to the external side only.
         err_msg_out[0] <= tl_err_in[0];
         err_msg_out[1] <= tl_err_in[1] | phy_err_in;
      end
   end

   // ========================================================
   // Plain storage; the internal lane is applied last and wins
   integer q;
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (q = 0; q < 8; q = q + 1) begin
            omsg_reg[q] <= `RST_WORD;
         end
         for (q = 0; q < 2; q = q + 1) begin
            odb_reg[q] <= `RST_WORD;
            scr_reg[q] <= `RST_WORD;
            ctrl_reg[q] <= `RST_CTRL;
         end
         paddr_reg <= `RST_WORD;
         pdata_reg <= `RST_WORD;
      end else begin
         for (q = 1; q >= 0; q = q - 1) begin
            if (wr_w[q]) begin
               if (off_w[q*11 +: 11] >= `OFF_OMSG0 &&
                   off_w[q*11 +: 11] <= `OFF_OMSG3) begin
                  omsg_reg[{tgt_w[q], off_w[q*11+2 +: 2]}] <=
                     req_wdata_in[q*32 +: 32];
               end
               case (off_w[q*11 +: 11])
                  `OFF_ODB: odb_reg[tgt_w[q]] <=
                     req_wdata_in[q*32 +: 32];
                  // No flag or mask is touched here.
                  `OFF_SCR0: scr_reg[0] <=
                     req_wdata_in[q*32 +: 32];
                  `OFF_SCR1: scr_reg[1] <=
                     req_wdata_in[q*32 +: 32];
                  `OFF_CTRL: ctrl_reg[tgt_w[q]] <=
                     req_wdata_in[q*32 +: 2];
                  `OFF_PADDR: if (!tgt_w[q]) begin
                     paddr_reg <= req_wdata_in[q*32 +: 32];
                  end
                  `OFF_PDATA: if (!tgt_w[q]) begin
                     pdata_reg <= req_wdata_in[q*32 +: 32];
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // ========================================================
   // External-side configuration issue
   wire [1:0] go_w;
   assign go_w[0] = wr_w[0] & ~tgt_w[0] &
      (off_w[10:0] == `OFF_PGO);
   assign go_w[1] = wr_w[1] & ~tgt_w[1] &
      (off_w[21:11] == `OFF_PGO);
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         punch_valid_out <= 1'b0;
         punch_write_out <= 1'b0;
         punch_addr_out <= `RST_WORD;
         punch_data_out <= `RST_WORD;
         pres_reg <= `RST_WORD;
      end else begin
         punch_valid_out <= |go_w;
         if (|go_w) begin
            punch_write_out <= go_w[0] ?
               req_wdata_in[`PGO_WRITE_BIT] :
               req_wdata_in[32 + `PGO_WRITE_BIT];
            punch_addr_out <= paddr_reg;
            punch_data_out <= pdata_reg;
         end
         if (punch_done_in) begin
            pres_reg <= punch_rdata_in;
         end
      end
   end

   // ========================================================
   // Read answers, one cycle after the request
   integer r;
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rsp_valid_out <= 2'h0;
         rsp_data_out <= 64'h0;
      end else begin
         for (r = 0; r < 2; r = r + 1) begin
            rsp_valid_out[r] <= req_valid_in[r];
            // A blocked access still answers, with zero data.
            rsp_data_out[r*32 +: 32] <= acc_w[r] ?
               rd_word(tgt_w[r], off_w[r*11 +: 11]) :
               `RST_WORD;
         end
      end
   end
endmodule // ntb_ipc

// ### bench/ntb_ipc_sva.sv
// Purpose: Port-level checks of the bridge block.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes: Bound to every instance of ntb_ipc.
`timescale 1ns/100ps
module ntb_ipc_chk (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Register access
   input wire [1:0] req_valid_in,
   input wire [1:0] req_cfg_in,
   input wire [1:0] req_write_in,
   input wire [23:0] req_addr_in,
   input wire [1:0] rsp_valid_out,
   // Packets
   input wire [1:0] pkt_valid_in,
   input wire [1:0] pkt_last_in,
   input wire [1:0] pkt_has_ecrc_in,
   input wire [1:0] fwd_ecrc_valid_out,
   // Errors and punch through
   input wire phy_err_in,
   input wire [1:0] tl_err_in,
   input wire [1:0] err_msg_out,
   input wire punch_valid_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   a_rsp_lane_zero: assert property (
      req_valid_in[0] |=> rsp_valid_out[0])
      else $error("lane zero request unanswered");
   a_rsp_lane_one: assert property (
      req_valid_in[1] |=> rsp_valid_out[1])
      else $error("lane one request unanswered");
   a_rsp_has_cause: assert property (
      rsp_valid_out[0] |-> $past(req_valid_in[0]))
      else $error("answer without request");
   a_phy_to_ext: assert property (
      phy_err_in |=> err_msg_out[1])
      else $error("link error not sent outside");
   a_phy_not_int: assert property (
      phy_err_in && !tl_err_in[0] |=> !err_msg_out[0])
      else $error("link error sent inside");
   a_tl_internal: assert property (
      tl_err_in[0] |=> err_msg_out[0])
      else $error("internal error not reported");
   a_tl_external: assert property (
      tl_err_in[1] |=> err_msg_out[1])
      else $error("external error not reported");
   // The checker stage and the output stage each add one cycle.
   a_fwd_after_last: assert property (
      pkt_valid_in[0] && pkt_last_in[0] && pkt_has_ecrc_in[0] |->
      ##2 fwd_ecrc_valid_out[0])
      else $error("no forwarded crc");
   a_fwd_has_cause: assert property (
      fwd_ecrc_valid_out[1] |->
      $past(pkt_valid_in[1] && pkt_last_in[1] && pkt_has_ecrc_in[1], 2))
      else $error("forwarded crc without packet");
   a_punch_issue: assert property (
      req_valid_in[0] && req_cfg_in[0] && req_write_in[0] &&
      req_addr_in[11:0] == 12'h448 |=> punch_valid_out)
      else $error("punch request not issued");
endmodule // ntb_ipc_chk
bind ntb_ipc ntb_ipc_chk u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
   .req_valid_in(req_valid_in), .req_cfg_in(req_cfg_in),
   .req_write_in(req_write_in), .req_addr_in(req_addr_in),
   .rsp_valid_out(rsp_valid_out), .pkt_valid_in(pkt_valid_in),
   .pkt_last_in(pkt_last_in), .pkt_has_ecrc_in(pkt_has_ecrc_in),
   .fwd_ecrc_valid_out(fwd_ecrc_valid_out), .phy_err_in(phy_err_in),
   .tl_err_in(tl_err_in), .err_msg_out(err_msg_out),
   .punch_valid_out(punch_valid_out));

// ### bench/cfg_target.sv
// Purpose: External-side configuration target for punch through.
// Assumes: One request outstanding at a time.
// Notes: Answers after a delay chosen by the bench, zero for fast.
`timescale 1ns/100ps
module cfg_target (
   // Clock and reset
   input wire sys_clk_in,
   input wire rstn_in,
   // Request from the bridge
   input wire punch_valid_in,
   input wire punch_write_in,
   input wire [31:0] punch_addr_in,
   input wire [31:0] punch_data_in,
   input wire [3:0] delay_in,
   // Completion to the bridge
   output reg punch_done_out,
   output reg [31:0] punch_rdata_out
);
   reg [31:0] mem_reg [0:3];
   reg [3:0] cnt_reg;
   reg busy_reg;
   reg wr_reg;
   reg [1:0] idx_reg;
   always @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_reg <= 4'h0;
         busy_reg <= 1'b0;
         wr_reg <= 1'b0;
         idx_reg <= 2'h0;
         punch_done_out <= 1'b0;
         punch_rdata_out <= 32'h0;
      end else begin
         punch_done_out <= 1'b0;
         // Data means nothing without done, so it never holds still.
         punch_rdata_out <= ~punch_rdata_out;
         if (punch_valid_in) begin
            busy_reg <= 1'b1;
            cnt_reg <= delay_in;
            wr_reg <= punch_write_in;
            idx_reg <= punch_addr_in[3:2];
            if (punch_write_in)
               mem_reg[punch_addr_in[3:2]] <= punch_data_in;
         end else if (busy_reg) begin
            if (cnt_reg == 4'h0) begin
               busy_reg <= 1'b0;
               punch_done_out <= 1'b1;
               punch_rdata_out <= wr_reg ? 32'h0 : mem_reg[idx_reg];
            end else
               cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end
endmodule // cfg_target

// ### bench/test_ntb_ipc.sv
// Purpose: Self-checking bench for the bridge block.
// Assumes: Inputs change on the falling edge.
// Notes: Each access leaves one idle cycle before the next.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module test_ntb_ipc;
   reg sys_clk_in = 1'b0;
   reg rstn_in = 1'b0;
   reg [1:0] req_valid_in = 2'h0, req_cfg_in = 2'h0, req_write_in = 2'h0;
   reg [23:0] req_addr_in = 24'h0;
   reg [63:0] req_wdata_in = 64'h0;
   reg [1:0] pkt_start_in = 2'h0, pkt_valid_in = 2'h0, pkt_last_in = 2'h0;
   reg [1:0] pkt_has_ecrc_in = 2'h0, tl_err_in = 2'h0;
   reg [63:0] pkt_orig_in = 64'h0, pkt_mod_in = 64'h0, pkt_ecrc_in = 64'h0;
   reg phy_err_in = 1'b0;
   reg c_sel = 1'b1;
   reg nf;
   reg [3:0] delay = 4'h0;
   reg [31:0] rd, v, m;
   wire [1:0] rsp_valid_out, irq_out, fwd_ecrc_valid_out;
   wire [1:0] nonfatal_msg_out, err_msg_out;
   wire [63:0] rsp_data_out, fwd_ecrc_out;
   wire punch_valid_out, punch_write_out, punch_done_in;
   wire [31:0] punch_addr_out, punch_data_out, punch_rdata_in;
   integer num_errors = 0, tests_run = 0, cycles = 0, s, i;
   ntb_ipc u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .req_valid_in(req_valid_in), .req_cfg_in(req_cfg_in),
      .req_write_in(req_write_in), .req_addr_in(req_addr_in),
      .req_wdata_in(req_wdata_in), .rsp_valid_out(rsp_valid_out),
      .rsp_data_out(rsp_data_out), .irq_out(irq_out),
      .pkt_start_in(pkt_start_in), .pkt_valid_in(pkt_valid_in),
      .pkt_last_in(pkt_last_in), .pkt_orig_in(pkt_orig_in),
      .pkt_mod_in(pkt_mod_in), .pkt_has_ecrc_in(pkt_has_ecrc_in),
      .pkt_ecrc_in(pkt_ecrc_in), .fwd_ecrc_valid_out(fwd_ecrc_valid_out),
      .fwd_ecrc_out(fwd_ecrc_out), .phy_err_in(phy_err_in),
      .tl_err_in(tl_err_in), .nonfatal_msg_out(nonfatal_msg_out),
      .err_msg_out(err_msg_out), .punch_valid_out(punch_valid_out),
      .punch_write_out(punch_write_out), .punch_addr_out(punch_addr_out),
      .punch_data_out(punch_data_out), .punch_done_in(punch_done_in),
      .punch_rdata_in(punch_rdata_in));
   cfg_target u_target (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .punch_valid_in(punch_valid_out), .punch_write_in(punch_write_out),
      .punch_addr_in(punch_addr_out), .punch_data_in(punch_data_out),
      .delay_in(delay), .punch_done_out(punch_done_in),
      .punch_rdata_out(punch_rdata_in));
   always #25 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_sim;
      end
   end
   task end_sim;
      begin
         if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // ==========================================================
   // Register access and expectations
   task acc(input integer l, input w, input [11:0] a, input [31:0] d);
      begin
         @(negedge sys_clk_in);
         req_valid_in[l] = 1'b1;
         req_cfg_in[l] = c_sel;
         req_write_in[l] = w;
         req_addr_in[12*l +: 12] = a;
         req_wdata_in[32*l +: 32] = d;
         @(negedge sys_clk_in);
         `CHK(rsp_valid_out[l], 1'b1)
         rd = rsp_data_out[32*l +: 32];
         req_valid_in[l] = 1'b0;
         req_wdata_in[32*l +: 32] = ~d;
      end
   endtask
   task wr(input integer l, input [11:0] a, input [31:0] d);
      acc(l, 1'b1, a, d);
   endtask
   task ck(input integer l, input [11:0] a, input [31:0] e);
      begin
         acc(l, 1'b0, a, 32'h0);
         `CHK(rd, e)
      end
   endtask
   function [31:0] crc(input [31:0] c, input [31:0] d);
      integer k;
      begin
         crc = c;
         for (k = 31; k >= 0; k--)
            crc = {crc[30:0], 1'b0} ^
               ((crc[31] ^ d[k]) ? 32'h04c1_1db7 : 32'h0);
      end
   endfunction
   task punch(input [31:0] a, input [31:0] d, input w, input [31:0] e);
      integer k;
      begin
         wr(0, 12'h440, a);
         wr(0, 12'h444, d);
         wr(0, 12'h448, {31'h0, w});
         `CHK({punch_valid_out, punch_write_out}, {1'b1, w})
         `CHK(punch_addr_out, a)
         `CHK(punch_data_out, d)
         for (k = 0; k < 20 && punch_done_in !== 1'b1; k++)
            @(negedge sys_clk_in);
         ck(0, 12'h44c, e);
      end
   endtask
   task pkt(input integer l, input integer n, input bad);
      reg [31:0] co, cm, o, md;
      integer k;
      begin
         co = 32'hffff_ffff;
         cm = co;
         for (k = 0; k < n; k++) begin
            o = $urandom;
            md = $urandom;
            co = crc(co, o);
            cm = crc(cm, md);
            @(negedge sys_clk_in);
            pkt_valid_in[l] = 1'b1;
            pkt_start_in[l] = (k == 0);
            pkt_last_in[l] = (k == n - 1);
            pkt_has_ecrc_in[l] = (k == n - 1);
            pkt_orig_in[32*l +: 32] = o;
            pkt_mod_in[32*l +: 32] = md;
            pkt_ecrc_in[32*l +: 32] = bad ? co : ~co;
         end
         @(negedge sys_clk_in);
         pkt_valid_in[l] = 1'b0;
         pkt_start_in[l] = 1'b0;
         pkt_last_in[l] = 1'b0;
         pkt_has_ecrc_in[l] = 1'b0;
         @(negedge sys_clk_in);
         `CHK(fwd_ecrc_valid_out[l], 1'b1)
         `CHK(fwd_ecrc_out[32*l +: 32], bad ? cm : ~cm)
         nf = nonfatal_msg_out[l];
         @(negedge sys_clk_in);
         nf = nf | nonfatal_msg_out[l];
         `CHK(nf, bad && l == 0)
         ck(l, 12'h438, {31'h0, bad});
         wr(l, 12'h438, 32'h1);
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rd = $urandom(32'h4f16);
      repeat (10) @(negedge sys_clk_in);
      rstn_in = 1'b1;
      for (s = 0; s < 2; s++)
         for (i = 0; i < 4; i++) begin
            c_sel = $urandom;
            v = $urandom;
            wr(s, 12'h400 + 4 * i, v);
            ck(s, 12'h400 + 4 * i, v);
            wr(1 - s, 12'h410 + 4 * i, ~v);
            ck(1 - s, 12'h410 + 4 * i, v);
            ck(1 - s, 12'h428, 32'h1 << i);
            `CHK(irq_out[1 - s], 1'b1)
            wr(1 - s, 12'h428, 32'hf);
            repeat (2) @(negedge sys_clk_in);
            `CHK(irq_out[1 - s], 1'b0)
         end
      for (s = 0; s < 2; s++) begin
         v = (s == 0) ? 32'hffff_ffff : $urandom;
         m = $urandom;
         wr(s, 12'h420, v);
         ck(s, 12'h420, v);
         ck(1 - s, 12'h424, v);
         ck(1 - s, 12'h428, 32'h10);
         wr(1 - s, 12'h424, m);
         ck(1 - s, 12'h424, v & ~m);
         wr(1 - s, 12'h424, 32'hffff_ffff);
         ck(1 - s, 12'h424, 32'h0);
         ck(1 - s, 12'h428, 32'h0);
      end
      wr(0, 12'h430, v);
      ck(1, 12'h430, v);
      wr(1, 12'h434, ~v);
      ck(0, 12'h434, ~v);
      ck(0, 12'h428, 32'h0);
      ck(1, 12'h428, 32'h0);
      `CHK(irq_out, 2'h0)
      ck(0, 12'h7fc, 32'h0);
      c_sel = 1'b1;
      wr(0, 12'hc00, v);
      ck(1, 12'h400, v);
      wr(1, 12'h43c, 32'h1);
      wr(0, 12'hc00, ~v);
      ck(0, 12'hc00, 32'h0);
      c_sel = 1'b0;
      ck(0, 12'hc00, v);
      c_sel = 1'b1;
      wr(1, 12'h43c, 32'h0);
      wr(0, 12'h428, 32'hf);
      for (i = 0; i < 2; i++) begin
         delay = (i == 0) ? 4'h0 : 4'h9;
         v = $urandom;
         m = $urandom & 32'hc;
         punch(m, v, 1'b1, 32'h0);
         punch(m, 32'h0, 1'b0, v);
      end
      wr(0, 12'h43c, 32'h2);
      for (i = 0; i < 8; i++)
         pkt(i % 2, 1 + 2 * (i / 4), i / 2 % 2);
      for (i = 0; i < 6; i++) begin
         @(negedge sys_clk_in);
         m = (i == 0) ? 32'h1 : $urandom;
         phy_err_in = m[0];
         tl_err_in = m[2:1];
         @(negedge sys_clk_in);
         phy_err_in = 1'b0;
         tl_err_in = 2'h0;
         `CHK(err_msg_out, {m[2] | m[0], m[1]})
      end
      end_sim;
   end
endmodule // test_ntb_ipc
